// ==== common/abm_pkg.sv ====
/*
 bus-cycle sequencer package: state codes, cycle kinds, request and pin bundles.
 assumes a single processor clock; each bus state lasts half a clock.
*/
package abm_pkg;

    localparam int ADDR_W      = 23;
    localparam int DATA_W      = 16;
    localparam int FC_W        = 3;
    localparam int SYNC_STAGES = 2;

    // bus state numbers; one state per half clock
    localparam logic [4:0] ST_ADDR_ON   = 5'h01;
    localparam logic [4:0] ST_STROBE    = 5'h02;
    localparam logic [4:0] ST_WDATA     = 5'h03;
    localparam logic [4:0] ST_WSTROBE   = 5'h04;
    localparam logic [4:0] ST_WAIT_PT   = 5'h05;
    localparam logic [4:0] ST_LATCH     = 5'h06;
    localparam logic [4:0] ST_NEGATE    = 5'h07;
    localparam logic [4:0] ST_MOD_LAST  = 5'h0b;
    localparam logic [4:0] ST_RMW_DIR   = 5'h0e;
    localparam logic [4:0] ST_RMW_WDATA = 5'h0f;
    localparam logic [4:0] ST_RMW_STRB  = 5'h10;
    localparam logic [4:0] ST_RMW_WAIT  = 5'h11;
    localparam logic [4:0] ST_RMW_LAST  = 5'h13;

    typedef enum logic [1:0]
    {
        ABM_KIND_READ  = 2'b00,
        ABM_KIND_WRITE = 2'b01,
        ABM_KIND_RMW   = 2'b10
    } abm_kind_type;

    typedef enum logic [1:0]
    {
        ABM_IDLE = 2'b00,
        ABM_RUN  = 2'b01,
        ABM_WAIT = 2'b10
    } abm_fsm_type;

    typedef struct packed
    {
        abm_kind_type          kind;
        logic                  word;
        logic [ADDR_W-1:0]     addr;
        logic                  byte_select_bit;
        logic [FC_W-1:0]       cycle_type;
        logic [DATA_W-1:0]     wdata;
    } abm_req_type;

    typedef struct packed
    {
        logic                  addr_oe;
        logic [ADDR_W-1:0]     addr;
        logic [FC_W-1:0]       cycle_type;
        logic                  read_write;
        logic                  addr_valid_strobe_n;
        logic                  upper_byte_strobe_n;
        logic                  lower_byte_strobe_n;
        logic                  data_oe;
        logic [DATA_W-1:0]     data_out;
    } abm_pins_type;

endpackage

// ==== src/abm_master.sv ====
/*
 asynchronous bus cycle master: read, write and read-modify-write sequencing.
 assumes slaves answer with an asynchronous active-low acknowledge; pins are
 split into value and enable, the bench resolves the wires.
*/
`timescale 1ns/1ps
module abm_master
    import abm_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              req_valid,
    input  abm_req_type            req,
    output logic                   req_ready,
    input  wire logic [DATA_W-1:0] modify_data,
    input  wire logic              transfer_ack_n,
    input  wire logic [DATA_W-1:0] data_in,
    output abm_pins_type           pins,
    output logic [DATA_W-1:0]      read_data,
    output logic                   read_done,
    output logic                   cycle_done
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    //
    // one clock covers two bus states: an even state on the rising phase and
    // the following odd state. state_reg holds the even one of the pair.
    abm_fsm_type       fsm_reg;
    abm_fsm_type       fsm_next;
    logic [4:0]        state_reg;
    logic [4:0]        state_next;
    abm_req_type       req_reg;
    abm_pins_type      pins_reg;
    abm_pins_type      pins_next;
    logic [DATA_W-1:0] rdata_reg;
    logic              rdone_reg;
    logic              cdone_reg;
    logic              ready_reg;
    logic              ack_sync;

    abm_sync #(
        .RESET_VAL (1'b1)
    ) u_ack_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (transfer_ack_n),
        .sync_out (ack_sync)
    );

    // read data is only trusted under the synchronised acknowledge, which trails
    // the slave by two clocks; two stages here keep the captured word clean
    logic [DATA_W-1:0] din_meta_reg;
    logic [DATA_W-1:0] din_sync_reg;

    always_ff @(posedge clock)
    begin
        din_meta_reg <= data_in;
        din_sync_reg <= din_meta_reg;
    end

    // bit 0 drives the upper strobe, bit 1 the lower; both low for a word
    function automatic logic [1:0] strobe_pick(input logic word, input logic bsel);
        begin
            if (word)
                strobe_pick = 2'b00;
            else if (!bsel)
                strobe_pick = 2'b10;
            else
                strobe_pick = 2'b01;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode
    // each clock pair is named by its even state, one below the odd state
    wire [4:0]  wait_pair  = ST_WAIT_PT - 5'h01;
    wire [4:0]  rmw_wait   = ST_RMW_WAIT - 5'h01;
    wire [4:0]  mod_pair   = ST_MOD_LAST - 5'h01;
    wire [4:0]  rmw_end    = ST_RMW_LAST - 5'h01;
    wire        is_rmw     = (req_reg.kind == ABM_KIND_RMW);
    wire        is_write   = (req_reg.kind == ABM_KIND_WRITE);
    wire [1:0]  strb_act   = strobe_pick(req_reg.word & ~is_rmw, req_reg.byte_select_bit);
    wire        ack_seen   = ~ack_sync;
    wire        at_wait_pt = (state_reg == wait_pair) || (state_reg == rmw_wait);
    wire        at_latch   = (state_reg == ST_LATCH) && !is_write;
    wire        at_end     = is_rmw ? (state_reg == rmw_end) : (state_reg == ST_LATCH);
    wire        at_mod_end = is_rmw && (state_reg == mod_pair);
    wire        start      = req_valid && ready_reg;
    wire        latch_now  = (fsm_reg == ABM_RUN) && at_latch;
    wire        end_now    = (fsm_reg == ABM_RUN) && at_end;
    wire        mod_take   = (fsm_reg == ABM_RUN) && at_mod_end;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing
    always_comb
    begin
        fsm_next   = fsm_reg;
        state_next = state_reg;
        case (fsm_reg)
            ABM_IDLE:
            begin
                if (start)
                begin
                    fsm_next   = ABM_RUN;
                    state_next = 5'h00;
                end
            end
            ABM_RUN:
            begin
                if (at_wait_pt && !ack_seen)
                    fsm_next = ABM_WAIT;
                else if (at_end)
                    fsm_next = ABM_IDLE;
                else
                    state_next = state_reg + 5'h02;
            end
            ABM_WAIT:
            begin
                // a wait pair replaces the acknowledge pair until ack shows
                if (ack_seen)
                begin
                    fsm_next   = ABM_RUN;
                    state_next = state_reg + 5'h02;
                end
            end
            default:
            begin
                fsm_next   = ABM_IDLE;
                state_next = 5'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin values for the coming clock. a clock spans an even and odd state;
    // outputs reflect the odd state, so odd-state changes after state 0
    // (1: address, 3/15: data, 5/17: wait, 7/19: negate) show one half early,
    // while even-state changes (2, 4, 14, 16) take effect on time.
    logic       in_run;
    logic [4:0] s;
    always_comb
    begin
        in_run    = (fsm_next != ABM_IDLE);
        s         = state_next;
        pins_next = pins_reg;
        if (!in_run)
        begin
            pins_next.addr_oe             = 1'b0;
            pins_next.addr_valid_strobe_n = 1'b1;
            pins_next.upper_byte_strobe_n = 1'b1;
            pins_next.lower_byte_strobe_n = 1'b1;
            pins_next.data_oe             = 1'b0;
            pins_next.read_write          = 1'b1;
        end
        else if (fsm_reg == ABM_IDLE)
        begin
            // states 0 and 1: function code and read high, then address
            pins_next.cycle_type          = req.cycle_type;
            pins_next.read_write          = 1'b1;
            pins_next.addr                = req.addr;
            pins_next.addr_oe             = 1'b1;
            pins_next.addr_valid_strobe_n = 1'b1;
            pins_next.upper_byte_strobe_n = 1'b1;
            pins_next.lower_byte_strobe_n = 1'b1;
            pins_next.data_oe             = 1'b0;
        end
        else
        begin
            if (s == ST_STROBE)
            begin
                pins_next.addr_valid_strobe_n = 1'b0;
                if (is_write)
                begin
                    pins_next.read_write = 1'b0;
                    pins_next.data_out   = req_reg.wdata;
                    pins_next.data_oe    = 1'b1;
                end
                else
                begin
                    pins_next.upper_byte_strobe_n = strb_act[0];
                    pins_next.lower_byte_strobe_n = strb_act[1];
                end
            end
            if (s == ST_WSTROBE && is_write)
            begin
                pins_next.upper_byte_strobe_n = strb_act[0];
                pins_next.lower_byte_strobe_n = strb_act[1];
            end
            if (s == ST_LATCH)
            begin
                pins_next.upper_byte_strobe_n = 1'b1;
                pins_next.lower_byte_strobe_n = 1'b1;
                if (!is_rmw)
                    pins_next.addr_valid_strobe_n = 1'b1;
                else
                    pins_next.addr_valid_strobe_n = 1'b0;
            end
            if (is_rmw && s == ST_RMW_DIR)
            begin
                pins_next.read_write = 1'b0;
                pins_next.data_out   = req_reg.wdata;
                pins_next.data_oe    = 1'b1;
            end
            if (is_rmw && s == ST_RMW_STRB)
            begin
                pins_next.upper_byte_strobe_n = strb_act[0];
                pins_next.lower_byte_strobe_n = strb_act[1];
            end
            if (is_rmw && s == rmw_end)
            begin
                pins_next.addr_valid_strobe_n = 1'b1;
                pins_next.upper_byte_strobe_n = 1'b1;
                pins_next.lower_byte_strobe_n = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            fsm_reg   <= ABM_IDLE;
            state_reg <= 5'h00;
            ready_reg <= 1'b0;
        end
        else
        begin
            fsm_reg   <= fsm_next;
            state_reg <= state_next;
            ready_reg <= (fsm_next == ABM_IDLE) && !start;
        end
    end

    // pins come straight from here, so every strobe edge is glitch free
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            pins_reg <= '{addr_oe: 1'b0, addr: '0, cycle_type: '0, read_write: 1'b1,
                          addr_valid_strobe_n: 1'b1, upper_byte_strobe_n: 1'b1,
                          lower_byte_strobe_n: 1'b1, data_oe: 1'b0, data_out: '0};
        else
            pins_reg <= pins_next;
    end

    // the modified byte replaces the write data while the address strobe holds
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            req_reg <= '0;
        else if (start)
            req_reg <= req;
        else if (mod_take)
            req_reg.wdata <= modify_data;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rdata_reg <= '0;
            rdone_reg <= 1'b0;
            cdone_reg <= 1'b0;
        end
        else
        begin
            rdone_reg <= latch_now;
            cdone_reg <= end_now;
            if (latch_now)
                rdata_reg <= din_sync_reg;
        end
    end

    assign pins      = pins_reg;
    assign read_data = rdata_reg;
    assign read_done = rdone_reg;
    assign cycle_done = cdone_reg;
    assign req_ready = ready_reg;

endmodule

// ==== src/abm_sync.sv ====
/*
 two flip-flop synchroniser for one asynchronous level.
 assumes the input may change at any time relative to clock.
*/
`timescale 1ns/1ps
module abm_sync
    import abm_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
)
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

// ==== test/abm_master_sva.sv ====
/*
 checker for the bus-cycle sequencer: pin sequencing of read, write and read-modify-write.
 assumes the top module's ports only; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module abm_master_chk
    import abm_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              req_valid,
    input  abm_req_type            req,
    input  wire logic              req_ready,
    input  wire logic [DATA_W-1:0] modify_data,
    input  wire logic              transfer_ack_n,
    input  wire logic [DATA_W-1:0] data_in,
    input  abm_pins_type           pins,
    input  wire logic [DATA_W-1:0] read_data,
    input  wire logic              read_done,
    input  wire logic              cycle_done
);
    wire logic take = req_valid && req_ready;
    wire logic eff_word = req.word && (req.kind != ABM_KIND_RMW);
    wire logic up_n = !eff_word && req.byte_select_bit;
    wire logic lo_n = !eff_word && !req.byte_select_bit;
    wire logic ds_n = pins.upper_byte_strobe_n && pins.lower_byte_strobe_n;
    abm_kind_type kind_reg;
    logic [1:0]   as_rises_reg;
    logic [1:0]   ds_rises_reg;

    always_ff @(posedge clock)
    begin
        as_rises_reg <= (sys_rst || take) ? 2'h0 : as_rises_reg + 2'($rose(pins.addr_valid_strobe_n));
        ds_rises_reg <= (sys_rst || take) ? 2'h0 : ds_rises_reg + 2'($rose(ds_n));
        kind_reg <= take ? req.kind : kind_reg;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    chk_addr_launch: assert property (take |=> pins.addr_oe && pins.read_write && pins.addr_valid_strobe_n
        && pins.addr == $past(req.addr) && pins.cycle_type == $past(req.cycle_type)) else $error("launch wrong");
    chk_read_strobe: assert property (take && req.kind != ABM_KIND_WRITE |-> ##2 !pins.addr_valid_strobe_n
        && pins.read_write && pins.upper_byte_strobe_n == $past(up_n, 2)
        && pins.lower_byte_strobe_n == $past(lo_n, 2)) else $error("read strobes wrong");
    chk_write_turn: assert property (take && req.kind == ABM_KIND_WRITE |=> pins.read_write && !pins.data_oe
        ##1 !pins.read_write && pins.data_oe && !pins.addr_valid_strobe_n && ds_n
        && pins.data_out == $past(req.wdata, 2)) else $error("write turn wrong");
    chk_write_strobe: assert property (take && req.kind == ABM_KIND_WRITE |-> ##3
        pins.upper_byte_strobe_n == $past(up_n, 3) && pins.lower_byte_strobe_n == $past(lo_n, 3))
        else $error("write strobes wrong");
    chk_strobe_nest: assert property (pins.addr_valid_strobe_n |-> ds_n)
        else $error("byte strobe outside address strobe");
    chk_wait_hold: assert property (!ds_n && transfer_ack_n ##1 transfer_ack_n [*2] |-> !ds_n)
        else $error("strobes ended without ack");
    chk_done_counts: assert property (cycle_done |-> as_rises_reg == 2'h1
        && ds_rises_reg == ((kind_reg == ABM_KIND_RMW) ? 2'h2 : 2'h1)) else $error("strobe negation count wrong");
    chk_rmw_write: assert property ($fell(pins.read_write) && kind_reg == ABM_KIND_RMW |-> pins.data_oe
        && ds_n && !pins.addr_valid_strobe_n && pins.data_out == modify_data) else $error("modify write wrong");
    chk_bus_release: assert property (cycle_done |-> !pins.data_oe && !pins.addr_oe
        && pins.addr_valid_strobe_n) else $error("bus not released");

    cover property (cycle_done && kind_reg == ABM_KIND_READ);
    cover property (cycle_done && kind_reg == ABM_KIND_WRITE);
    cover property (cycle_done && kind_reg == ABM_KIND_RMW);
    cover property (!ds_n && transfer_ack_n [*3]);
endmodule

bind abm_master abm_master_chk chk_u (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .modify_data(modify_data), .transfer_ack_n(transfer_ack_n), .data_in(data_in),
    .pins(pins), .read_data(read_data), .read_done(read_done), .cycle_done(cycle_done));

// ==== test/abm_master_tb_top.sv ====
/*
 bench for the bus-cycle sequencer: reads, writes, stalls, read-modify-write.
 assumes the slave model on the far side and the bound checker.
*/
`timescale 1ns/1ps
module abm_master_tb_top
    import abm_pkg::*;
;
    logic              clock;
    logic              sys_rst;
    logic              req_valid;
    abm_req_type       req;
    logic              req_ready;
    logic [DATA_W-1:0] modify_data;
    logic [3:0]        stall;
    logic              transfer_ack_n;
    logic [DATA_W-1:0] data_in;
    abm_pins_type      pins;
    logic [DATA_W-1:0] read_data;
    logic              read_done;
    logic              cycle_done;
    logic [DATA_W-1:0] shadow [0:15];
    int                bad_count;
    int                total_checks;

    abm_master dut_u (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .modify_data(modify_data), .transfer_ack_n(transfer_ack_n), .data_in(data_in), .pins(pins),
        .read_data(read_data), .read_done(read_done), .cycle_done(cycle_done));
    abm_slave_model slave_u (.clock(clock), .sys_rst(sys_rst), .pins(pins), .stall(stall),
        .transfer_ack_n(transfer_ack_n), .data_in(data_in));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one whole bus cycle; reads are compared, the shadow follows every store
    task automatic xfer(input abm_kind_type k, input logic w, input logic [3:0] a, input logic b,
                        input logic [15:0] wd, output int n);
        logic [15:0] mask;
        int          rd_seen;
        mask = (w && k != ABM_KIND_RMW) ? 16'hffff : (b ? 16'h00ff : 16'hff00);
        n = 0;
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{k, w, {19'h0, a}, b, 3'h5, wd};
        do
            @(posedge clock);
        while (req_ready !== 1'b1 && n++ < 60);
        req_valid <= 1'b0;
        n = 0;
        rd_seen = 0;
        do
        begin
            @(posedge clock);
            rd_seen += (read_done === 1'b1) ? 1 : 0;
        end
        while (cycle_done !== 1'b1 && n++ < 90);
        check({15'h0, cycle_done}, 16'h0001);
        check(16'(rd_seen), (k != ABM_KIND_WRITE) ? 16'h0001 : 16'h0000);
        if (k != ABM_KIND_WRITE)
            check(read_data & mask, shadow[a] & mask);
        if (k != ABM_KIND_READ)
            shadow[a] = (shadow[a] & ~mask) | (((k == ABM_KIND_RMW) ? modify_data : wd) & mask);
    endtask

    task automatic test_reads();
        int n;
        xfer(ABM_KIND_READ, 1'b0, 4'h2, 1'b0, 16'h0, n);
        xfer(ABM_KIND_READ, 1'b0, 4'h2, 1'b1, 16'h0, n);
        xfer(ABM_KIND_READ, 1'b1, 4'h3, 1'b0, 16'h0, n);
        $display("test_reads done");
    endtask

    task automatic test_writes();
        int n;
        xfer(ABM_KIND_WRITE, 1'b1, 4'h5, 1'b0, 16'h3c5a, n);
        xfer(ABM_KIND_WRITE, 1'b0, 4'h5, 1'b0, 16'h7700, n);
        xfer(ABM_KIND_WRITE, 1'b0, 4'h5, 1'b1, 16'h00e1, n);
        xfer(ABM_KIND_READ, 1'b1, 4'h5, 1'b0, 16'h0, n);
        $display("test_writes done");
    endtask

    task automatic test_stall();
        int n0;
        int n1;
        xfer(ABM_KIND_READ, 1'b1, 4'h6, 1'b0, 16'h0, n0);
        stall <= 4'h6;
        xfer(ABM_KIND_READ, 1'b1, 4'h6, 1'b0, 16'h0, n1);
        check({15'h0, n1 == n0 + 6}, 16'h0001);
        xfer(ABM_KIND_WRITE, 1'b1, 4'h6, 1'b0, 16'h9d2b, n1);
        xfer(ABM_KIND_READ, 1'b1, 4'h6, 1'b1, 16'h0, n1);
        stall <= 4'h0;
        $display("test_stall done");
    endtask

    task automatic test_rmw();
        int n;
        stall <= 4'h2;
        xfer(ABM_KIND_RMW, 1'b0, 4'h7, 1'b0, 16'h0, n);
        xfer(ABM_KIND_RMW, 1'b1, 4'h9, 1'b1, 16'h0, n);
        stall <= 4'h0;
        xfer(ABM_KIND_READ, 1'b1, 4'h7, 1'b0, 16'h0, n);
        xfer(ABM_KIND_READ, 1'b1, 4'h9, 1'b0, 16'h0, n);
        $display("test_rmw done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial
    begin
        #200000;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        modify_data = 16'h8181;
        stall = 4'h0;
        bad_count = 0;
        total_checks = 0;
        for (int i = 0; i < 16; i++)
            shadow[i] = {i[3:0], 4'h6, ~i[3:0], 4'h9};
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        check({12'h0, pins.addr_oe, pins.data_oe, pins.addr_valid_strobe_n, pins.read_write}, 16'h0003);
        test_reads();
        test_writes();
        test_stall();
        test_rmw();
        wrap_up();
    end
endmodule

// ==== test/abm_slave_model.sv ====
/*
 slave model: sixteen-word memory that acknowledges after a stall count.
 assumes registered master pins on the shared clock.
*/
`timescale 1ns/1ps
module abm_slave_model
    import abm_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  abm_pins_type           pins,
    input  wire logic [3:0]        stall,
    output logic                   transfer_ack_n,
    output logic [DATA_W-1:0]      data_in
);
    logic [DATA_W-1:0] mem [0:15];
    logic [3:0]        wait_reg;
    wire logic [3:0] idx = pins.addr[3:0];
    wire logic sel = !pins.addr_valid_strobe_n;
    wire logic strobe = sel && !(pins.upper_byte_strobe_n && pins.lower_byte_strobe_n);

    initial
    begin
        transfer_ack_n = 1'b1;
        data_in = 16'h0;
        wait_reg = 4'h0;
        for (int i = 0; i < 16; i++)
            mem[i] = {i[3:0], 4'h6, ~i[3:0], 4'h9};
    end

    // undriven data toggles so a late capture cannot match by chance
    always @(posedge clock)
    begin
        if (sys_rst || !strobe || wait_reg < stall)
        begin
            transfer_ack_n <= 1'b1;
            data_in <= ~data_in;
            wait_reg <= strobe ? wait_reg + 4'h1 : 4'h0;
        end
        else
        begin
            transfer_ack_n <= 1'b0;
            if (pins.read_write)
                data_in <= mem[idx];
            if (!pins.read_write && !pins.upper_byte_strobe_n)
                mem[idx][15:8] <= pins.data_out[15:8];
            if (!pins.read_write && !pins.lower_byte_strobe_n)
                mem[idx][7:0] <= pins.data_out[7:0];
        end
    end
endmodule
